// *** hdl/irq_wake_defines.vh ***
`ifndef IRQ_WAKE_DEFINES_VH
`define IRQ_WAKE_DEFINES_VH
// Priority level codes
`define LVL_NONE 2'h0
`define LVL_LOW 2'h1
`define LVL_HIGH 2'h2
`define LVL_TOP 2'h3
// Vector table base and stride
`define VEC_BASE 17'h00003
`define VEC_STEP 17'h00008
`define VEC_COUNT 4'hA
// Standby mode codes
`define MODE_RUN 2'h0
`define MODE_HALT 2'h1
`define MODE_HOLD 2'h2
`define MODE_XHOLD 2'h3
// Pin synchroniser reset value: only the reset pin rests high
`define PIN_SYNC_IDLE 9'h004
// Source bit positions in the source vector
`define SRC_EXT0 0
`define SRC_EXT1 1
`define SRC_EXT2 2
`define SRC_T0L 3
`define SRC_EXT4 4
`define SRC_EXT3 5
`define SRC_BASE 6
`define SRC_T0H 7
`define SRC_T1L 8
`define SRC_T1H 9
`define SRC_SIOA 10
`define SRC_URX 11
`define SRC_SIOB 12
`define SRC_UTX 13
`define SRC_ADC 14
`define SRC_T6 15
`define SRC_T7 16
`define SRC_PWMA 17
`define SRC_PWMB 18
`define SRC_P0 19
`endif

// *** hdl/level_slot.v ***
`timescale 1ns/100ps
// Qualifies one vector: pending and enabled, with its assigned level
module level_slot (
    input wire pend_i,
    input wire en_i,
    input wire [1:0] lvl_i,
    input wire [1:0] cur_i,
    output wire [1:0] eff_o
);
    // Only a level strictly above the one in service competes
    assign eff_o = (pend_i && en_i && (lvl_i > cur_i)) ? lvl_i : 2'h0;
endmodule

// *** hdl/priority_interrupt_wake_unit.v ***
`timescale 1ns/100ps
// Behaviour
// (R1) Three levels: highest, high, low ranked
// (R2) Refuse levels equal or below serviced level
// (R3) Different vectors: highest level granted first
// (R4) Same level: lowest vector address wins
// (R5) Twenty sources mapped onto ten vectors
// (R6) Only vectors 0,1 may use highest
// (R7) Halt ends on interrupt or any reset
// (R8) Hold wakes on resets, ext 0/1/2/4, port0
// (R9) Ext 0/1 wake hold only level-sensitive
// (R10) Crystal hold adds base timer wake
// (R11) Grant branches to vector, records level
`include "irq_wake_defines.vh"
module priority_interrupt_wake_unit (
    input wire clk_i,
    input wire rst_n_i,
    input wire ext_request_0_i,
    input wire ext_request_1_i,
    input wire ext_request_2_i,
    input wire ext_request_3_i,
    input wire ext_request_4_i,
    input wire port0_request_i,
    input wire timer0_low_event_i,
    input wire timer0_high_event_i,
    input wire timer1_low_event_i,
    input wire timer1_high_event_i,
    input wire base_timer_event_i,
    input wire timer_six_event_i,
    input wire timer_seven_event_i,
    input wire pwm_channel_a_i,
    input wire pwm_channel_b_i,
    input wire sync_serial_port_a_i,
    input wire sync_serial_port_b_i,
    input wire async_serial_rx_i,
    input wire async_serial_tx_i,
    input wire adc_event_i,
    input wire [9:0] vec_enable_i,
    input wire [19:0] vec_level_i,
    input wire ext0_level_mode_i,
    input wire ext1_level_mode_i,
    input wire xtal_selected_i,
    input wire [1:0] standby_req_i,
    input wire reset_pin_n_i,
    input wire low_voltage_reset_i,
    input wire watchdog_reset_i,
    input wire ack_i,
    input wire reti_i,
    output wire irq_o,
    output reg [16:0] vector_o,
    output wire [1:0] level_o,
    output wire [1:0] mode_o,
    output wire core_stop_o,
    output wire periph_stop_o,
    output wire base_timer_run_o
);
    localparam ST_RUN = 4'h1;
    localparam ST_HALT = 4'h2;
    localparam ST_HOLD = 4'h4;
    localparam ST_XHOLD = 4'h8;

    // Two-flop synchronisers on pin-side inputs
    reg [8:0] pin_s1_q;
    reg [8:0] pin_s2_q;
    wire [8:0] pin_raw;
    assign pin_raw = {ext_request_0_i, ext_request_1_i, ext_request_2_i,
                      ext_request_3_i, ext_request_4_i, port0_request_i,
                      reset_pin_n_i, low_voltage_reset_i, watchdog_reset_i};
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_s1_q <= `PIN_SYNC_IDLE; // No false reset after release
            pin_s2_q <= `PIN_SYNC_IDLE;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end
    wire e0 = pin_s2_q[8];
    wire e1 = pin_s2_q[7];
    wire e2 = pin_s2_q[6];
    wire e3 = pin_s2_q[5];
    wire e4 = pin_s2_q[4];
    wire p0 = pin_s2_q[3];
    wire rst_pin_n = pin_s2_q[2];
    wire lvr = pin_s2_q[1];
    wire wdr = pin_s2_q[0];
    wire any_reset = !rst_pin_n || lvr || wdr;

    // Previous sample for edge-detected external requests
    reg e0_prev_q;
    reg e1_prev_q;
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            e0_prev_q <= 1'b0;
            e1_prev_q <= 1'b0;
        end else begin
            e0_prev_q <= e0;
            e1_prev_q <= e1;
        end
    end
    wire e0_evt = ext0_level_mode_i ? e0 : (e0 && !e0_prev_q);
    wire e1_evt = ext1_level_mode_i ? e1 : (e1 && !e1_prev_q);

    // Sources folded onto vectors
    wire [9:0] vec_pend;
    assign vec_pend[0] = e0_evt; // [R5]
    assign vec_pend[1] = e1_evt; // [R5]
    assign vec_pend[2] = e2 || timer0_low_event_i || e4; // [R5]
    assign vec_pend[3] = e3 || base_timer_event_i; // [R5]
    assign vec_pend[4] = timer0_high_event_i; // [R5]
    assign vec_pend[5] = timer1_low_event_i || timer1_high_event_i; // [R5]
    assign vec_pend[6] = sync_serial_port_a_i || async_serial_rx_i; // [R5]
    assign vec_pend[7] = sync_serial_port_b_i || async_serial_tx_i; // [R5]
    assign vec_pend[8] = adc_event_i || timer_six_event_i ||
                         timer_seven_event_i || pwm_channel_a_i ||
                         pwm_channel_b_i; // [R5]
    assign vec_pend[9] = p0; // [R5]

    // Level in service is the top of a small nesting stack
    reg [1:0] stk_q [0:2];
    reg [1:0] depth_q;
    wire [1:0] cur_lvl = (depth_q == 2'h0) ? `LVL_NONE :
                         stk_q[depth_q - 2'h1];
    assign level_o = cur_lvl;

    // Legal level per vector; highest only on the first two
    wire [1:0] vec_lvl [0:9];
    wire [1:0] eff [0:9];
    genvar g;
    generate
        for (g = 0; g < 10; g = g + 1) begin : slot
            if (g < 2) begin : top_ok
                assign vec_lvl[g] = vec_level_i[2*g+1] ? `LVL_TOP
                                                        : `LVL_LOW; // [R6]
            end else begin : high_ok
                assign vec_lvl[g] = vec_level_i[2*g+1] ? `LVL_HIGH
                                                        : `LVL_LOW; // [R6]
            end
            level_slot u_slot (
                .pend_i(vec_pend[g]),
                .en_i(vec_enable_i[g]),
                .lvl_i(vec_lvl[g]),
                .cur_i(cur_lvl),
                .eff_o(eff[g])
            ); // [R2]
        end
    endgenerate

    // Pick highest level, ties to lowest vector index
    reg [1:0] best_lvl;
    reg [3:0] best_idx;
    integer i;
    always @* begin
        best_lvl = `LVL_NONE;
        best_idx = 4'h0;
        for (i = 9; i >= 0; i = i - 1) begin
            if (eff[i] != `LVL_NONE && eff[i] >= best_lvl) begin
                best_lvl = eff[i]; // [R1] [R3]
                best_idx = i[3:0]; // [R4]
            end
        end
    end
    wire win = best_lvl != `LVL_NONE;
    assign irq_o = win;

    // Vector address register and level stack update
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            vector_o <= `VEC_BASE;
            depth_q <= 2'h0;
            stk_q[0] <= `LVL_NONE;
            stk_q[1] <= `LVL_NONE;
            stk_q[2] <= `LVL_NONE;
        end else begin
            vector_o <= `VEC_BASE + {13'h0000, best_idx} * `VEC_STEP;
            if (ack_i && win && depth_q != 2'h3) begin
                stk_q[depth_q] <= best_lvl; // [R11]
                depth_q <= depth_q + 2'h1; // [R11]
            end else if (reti_i && depth_q != 2'h0) begin
                depth_q <= depth_q - 2'h1; // [R11]
            end
        end
    end

    // Standby sequencing
    reg [3:0] st_q;
    reg [3:0] st_d;
    wire hold_wake = any_reset || (e0 && ext0_level_mode_i) ||
                     (e1 && ext1_level_mode_i) || e2 || e4 || p0; // [R8] [R9]
    wire xhold_wake = hold_wake || base_timer_event_i; // [R10]
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_RUN: begin
                if (standby_req_i == `MODE_HALT) begin
                    st_d = ST_HALT;
                end else if (standby_req_i == `MODE_HOLD) begin
                    st_d = ST_HOLD;
                end else if (standby_req_i == `MODE_XHOLD) begin
                    st_d = xtal_selected_i ? ST_XHOLD : ST_HOLD; // [R10]
                end
            end
            ST_HALT: begin
                if (win || any_reset) begin
                    st_d = ST_RUN; // [R7]
                end
            end
            ST_HOLD: begin
                if (hold_wake) begin
                    st_d = ST_RUN; // [R8]
                end
            end
            ST_XHOLD: begin
                if (xhold_wake) begin
                    st_d = ST_RUN; // [R10]
                end
            end
            default: st_d = ST_RUN;
        endcase
    end
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q <= ST_RUN;
        end else begin
            st_q <= st_d;
        end
    end

    // Standby status outputs
    assign mode_o = (st_q == ST_HALT) ? `MODE_HALT :
                    (st_q == ST_HOLD) ? `MODE_HOLD :
                    (st_q == ST_XHOLD) ? `MODE_XHOLD : `MODE_RUN;
    assign core_stop_o = st_q != ST_RUN; // [R7]
    assign periph_stop_o = (st_q == ST_HOLD) || (st_q == ST_XHOLD); // [R8]
    assign base_timer_run_o = st_q != ST_HOLD; // [R10]
endmodule

// *** verif/irq_wake_monitor.sv ***
`timescale 1ns/100ps
// Watches grants, nesting and standby outputs of the unit
module irq_wake_monitor (
    input wire clk_i,
    input wire rst_n_i,
    input wire ack_i,
    input wire watchdog_reset_i,
    input wire xtal_selected_i,
    input wire [1:0] standby_req_i,
    input wire irq_o,
    input wire [16:0] vector_o,
    input wire [1:0] level_o,
    input wire [1:0] mode_o,
    input wire periph_stop_o,
    input wire base_timer_run_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Core takes the current winner
    sequence s_take;
        ack_i && irq_o;
    endsequence
    a_vec_table: assert property (vector_o[2:0] == 3'h3 &&
        vector_o <= 17'h0004B) else $error("vector off table");
    a_nest_up: assert property (s_take |=> level_o > $past(level_o))
        else $error("level not raised");
    a_top_mask: assert property (level_o == 2'h3 |-> !irq_o)
        else $error("request above top");
    a_top_vec: assert property (s_take and vector_o > 17'h0000B
        |=> level_o != 2'h3) else $error("top level misused");
    a_halt_wake: assert property (mode_o == 2'h1 && irq_o
        |=> mode_o == 2'h0) else $error("halt kept");
    a_xhold_run: assert property (mode_o == 2'h3
        |-> base_timer_run_o && periph_stop_o) else $error("xhold");
    a_wdt_wake: assert property ($rose(watchdog_reset_i) &&
        mode_o != 2'h0 |-> ##[1:4] mode_o == 2'h0) else $error("wake");
    a_xhold_fall: assert property (mode_o == 2'h0 && !xtal_selected_i
        && standby_req_i == 2'h3 |=> mode_o == 2'h2) else $error("fall");
endmodule

bind priority_interrupt_wake_unit irq_wake_monitor irq_wake_monitor_inst (
    .clk_i, .rst_n_i, .ack_i, .watchdog_reset_i, .xtal_selected_i,
    .standby_req_i, .irq_o, .vector_o, .level_o, .mode_o, .periph_stop_o,
    .base_timer_run_o);

// *** verif/core_model.sv ***
`timescale 1ns/100ps
// Core model: takes a steady request, returns once requests are gone
module core_model (
    input wire clk_i,
    input wire rst_n_i,
    input wire irq_i,
    input wire [3:0] wait_i,
    output reg ack_o = 1'b0,
    output reg reti_o = 1'b0
);
    reg irq_q;
    reg [3:0] cnt_q;
    reg [1:0] depth_q;
    // A wait_i of 4'hF blocks every acknowledge; returns still occur
    always @(posedge clk_i) begin
        irq_q <= irq_i;
        cnt_q <= cnt_q + 4'h1;
        ack_o <= 1'b0;
        reti_o <= 1'b0;
        if (!rst_n_i) begin
            cnt_q <= 4'h0;
            depth_q <= 2'h0;
        end else if (ack_o || reti_o) begin
            cnt_q <= 4'h0;
        end else if (irq_i && irq_q && cnt_q > wait_i) begin
            ack_o <= 1'b1;
            depth_q <= depth_q + 2'h1;
        end else if (!irq_i && depth_q != 2'h0 && cnt_q == 4'hF) begin
            reti_o <= 1'b1;
            depth_q <= depth_q - 2'h1;
        end
    end
endmodule

// *** verif/tb.sv ***
`timescale 1ns/100ps
// Drives requests and standby, checks grants and wake-up
module tb;
    reg clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg [19:0] src = 20'h0;
    reg [9:0] en = 10'h0;
    reg [19:0] lv = 20'h0;
    reg [1:0] sb = 2'h0;
    reg [3:0] wt = 4'hF;
    reg lm0 = 1'b1;
    reg xt = 1'b0;
    reg wd = 1'b0;
    reg lm1 = 1'b1;
    reg rpn = 1'b1;
    reg low_voltage_reset = 1'b0;
    reg [18:0] w;
    wire irq, ack, reti, cs, ps, br;
    wire [16:0] vec;
    wire [1:0] lvl, mode;
    integer num_errors = 0;
    integer comparisons = 0;
    integer n;
    integer rs = 0;
    initial forever #20 clk_i = ~clk_i;
    priority_interrupt_wake_unit priority_interrupt_wake_unit_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ext_request_0_i(src[0]),
        .ext_request_1_i(src[1]), .ext_request_2_i(src[2]),
        .timer0_low_event_i(src[3]), .ext_request_4_i(src[4]),
        .ext_request_3_i(src[5]), .base_timer_event_i(src[6]),
        .timer0_high_event_i(src[7]), .timer1_low_event_i(src[8]),
        .timer1_high_event_i(src[9]), .sync_serial_port_a_i(src[10]),
        .async_serial_rx_i(src[11]), .sync_serial_port_b_i(src[12]),
        .async_serial_tx_i(src[13]), .adc_event_i(src[14]),
        .timer_six_event_i(src[15]), .timer_seven_event_i(src[16]),
        .pwm_channel_a_i(src[17]), .pwm_channel_b_i(src[18]),
        .port0_request_i(src[19]), .vec_enable_i(en), .vec_level_i(lv),
        .ext0_level_mode_i(lm0), .ext1_level_mode_i(lm1),
        .xtal_selected_i(xt), .standby_req_i(sb), .reset_pin_n_i(rpn),
        .low_voltage_reset_i(low_voltage_reset), .watchdog_reset_i(wd), .ack_i(ack),
        .reti_i(reti), .irq_o(irq), .vector_o(vec), .level_o(lvl),
        .mode_o(mode), .core_stop_o(cs), .periph_stop_o(ps),
        .base_timer_run_o(br));
    core_model core_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .irq_i(irq), .wait_i(wt), .ack_o(ack), .reti_o(reti));
    // Vector served by each source position
    function [3:0] vof(input integer s);
        vof = s < 2 ? s[3:0] : s < 5 ? 4'h2 : s < 7 ? 4'h3 : s < 8 ? 4'h4 :
            s < 10 ? 4'h5 : s < 12 ? 4'h6 : s < 14 ? 4'h7 : s < 19 ? 4'h8 : 4'h9;
    endfunction
    // Stop outputs {core, peripherals, base timer run} in each mode
    function [2:0] stops(input [1:0] m);
        stops = m == 2'h0 ? 3'h1 : m == 2'h1 ? 3'h5 :
            m == 2'h2 ? 3'h6 : 3'h7;
    endfunction
    // Winner as {level, vector}: top level first, then lowest address
    function [18:0] win(input [1:0] cur);
        integer s;
        reg [3:0] v;
        reg [1:0] l;
        win = 19'h00003; // With no winner the first vector is shown
        for (s = 19; s >= 0; s = s - 1) begin
            v = vof(s);
            l = !lv[2*v+1] ? 2'h1 : v < 4'h2 ? 2'h3 : 2'h2;
            if (src[s] && en[v] && l > cur && l >= win[18:17])
                win = {l, 17'h00003 + {v, 3'h0}};
        end
    endfunction
    task cyc(input integer c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask
    task chk(input [16:0] g, input [16:0] e);
        comparisons = comparisons + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Let the core take one request, then drain back to no service
    task take(input [1:0] e);
        wt = 4'h0;
        for (n = 0; n < 20 && lvl == w[18:17] - e; n = n + 1) cyc(1);
        wt = 4'hF;
        chk({15'h0, lvl}, {15'h0, w[18:17]});
    endtask
    task drain;
        src = 20'h0;
        wt = 4'h0;
        for (n = 0; n < 99 && lvl != 2'h0; n = n + 1) cyc(1);
        wt = 4'hF;
        chk({15'h0, lvl}, 17'h0);
    endtask
    // Offer one source in a standby mode; e is the mode expected after
    task stby(input [1:0] m, input integer s, input [1:0] e);
        sb = m;
        cyc(1);
        sb = 2'h0;
        src[s] = 1'b1;
        cyc(6);
        chk({15'h0, mode}, {15'h0, e});
        chk({14'h0, cs, ps, br}, {14'h0, stops(e)});
        // Wake by watchdog, reset pin and low voltage in turn
        src = 20'h0;
        rs = rs + 1;
        wd = rs % 3 == 0;
        rpn = rs % 3 != 1;
        low_voltage_reset = rs % 3 == 2;
        cyc(1);
        wd = 1'b0;
        rpn = 1'b1;
        low_voltage_reset = 1'b0;
        cyc(6);
        chk({15'h0, mode}, 17'h0);
    endtask
    task test_done;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors = num_errors + 1;
        test_done;
    end
    initial begin
        void'($urandom(32'h321EDF48));
        cyc(6);
        rst_n_i = 1'b1;
        repeat (40) begin
            en = $urandom;
            lv = $urandom;
            src = $urandom & $urandom & $urandom;
            w = win(2'h0);
            cyc(4);
            chk({16'h0, irq}, {16'h0, |w[18:17]});
            chk(vec, w[16:0]);
            if (w[18:17] != 2'h0) take(w[18:17]);
            drain;
        end
        en = 10'h3FF;
        lv = 20'hAAAAA;
        src = 20'h80;
        w = win(2'h0);
        cyc(4);
        take(w[18:17]);
        src[3] = 1'b1;
        cyc(4);
        chk({16'h0, irq}, 17'h0);
        src[0] = 1'b1;
        w = win(2'h2);
        cyc(4);
        chk(vec, 17'h00003);
        take(2'h1);
        drain;
        lv = 20'h0;
        stby(2'h1, 7, 2'h0);
        stby(2'h2, 7, 2'h2);
        for (n = 0; n < 20; n = n + 1) if (n == 2 || n == 4 || n == 19 ||
            n == 0) stby(2'h2, n, 2'h0);
        stby(2'h2, 6, 2'h2);
        xt = 1'b1;
        stby(2'h3, 6, 2'h0);
        stby(2'h3, 1, 2'h0);
        stby(2'h3, 7, 2'h3);
        xt = 1'b0;
        stby(2'h3, 6, 2'h2);
        lm0 = 1'b0;
        lm1 = 1'b0;
        en = 10'h0;
        stby(2'h2, 0, 2'h2);
        stby(2'h2, 1, 2'h2);
        test_done;
    end
endmodule
